// >>> hdl/reset_cause_regs.vh
// Constants, register map and field layout of the reset-cause capture block.
// Functional notes
// - Pin-select registers have shadow copies; any unwritten difference in the RC_PPS_MASK bits triggers mismatch reset.
// - Mismatch reset sets status bit 9; only power-on or brown-out clears it.
// - Illegal opcode, uninitialized pointer or security fault reset and set bit 14.
// - Executing a fetched word that decodes illegal causes a device reset instead.
// - A fetched word whose upper eight bits are 0x3F is illegal.
// - Every reset clears working registers 0 to 14 and marks them uninitialized.
// - Using an uninitialized working register as an address pointer resets the device.
// - Flow changes into the protected segment cause a security reset.
// - Call, jump, computed jump, return and branch reloads are program-flow changes.
// - Reloads with an interrupt or trap vector are vector-flow changes.
// - Trap conflict sets bit 15; power-on or brown-out clears it.
// - Master clear pin reset sets bit 7; only power-on clears it.
// - Software reset instruction sets bit 6; power-on or brown-out clears it.
// - Watchdog time-out sets bit 4; power-save, watchdog-clear, power-on, brown-out clear it.
// - Power-save into sleep sets bit 3; power-on or brown-out clears it.
// - Power-save into idle sets bit 2; power-on or brown-out clears it.
// - Brown-out or power-on sets bit 1; power-on also sets bit 0; hardware never clears.
// - Software may set and clear every reset-cause flag.
`ifndef RESET_CAUSE_REGS_VH
`define RESET_CAUSE_REGS_VH

// Register byte offsets.
`define RC_OFF_STATUS    8'h00
`define RC_OFF_CTRL      8'h04
`define RC_OFF_SEG_BASE  8'h08
`define RC_OFF_SEG_LIMIT 8'h0c
`define RC_OFF_PPS0      8'h10
`define RC_OFF_PPS3      8'h1c
`define RC_OFF_WREG_INIT 8'h20

// Register select codes.
`define RC_SEL_STATUS    3'h0
`define RC_SEL_CTRL      3'h1
`define RC_SEL_SEG_BASE  3'h2
`define RC_SEL_SEG_LIMIT 3'h3
`define RC_SEL_PPS       3'h4
`define RC_SEL_WREG_INIT 3'h5
`define RC_SEL_NONE      3'h7

// Status flag positions.
`define RC_BIT_TRAP      15
`define RC_BIT_ILLEGAL   14
`define RC_BIT_MISMATCH  9
`define RC_BIT_EXT       7
`define RC_BIT_SOFT      6
`define RC_BIT_WDT       4
`define RC_BIT_SLEEP     3
`define RC_BIT_IDLE      2
`define RC_BIT_BOR       1
`define RC_BIT_POR       0

// Status implemented bits and power-on value.
`define RC_STATUS_MASK   16'hc2df
`define RC_STATUS_RESET  16'h0003
`define RC_STATUS_KEEP_BOR 16'h0083

// Control, segment and pin-select layout.
`define RC_CTRL_SEC_EN   0
`define RC_SEG_RESET     24'h00_0000
`define RC_PPS_MASK      16'h1f1f
`define RC_PPS_COUNT     4

// Instruction decode.
`define RC_ILLEGAL_OP    8'h3f

// AXI responses.
`define RC_RESP_OKAY     2'b00
`define RC_RESP_SLVERR   2'b10

`endif

// >>> hdl/wreg_init_tracker.v
// Working-register initialization tracker with pointer-use checking.
`timescale 1ns/1ps
`default_nettype none

module wreg_init_tracker (
	// Clock and reset.
	input  wire        aclk,
	input  wire        aresetn,
	// Device reset request.
	input  wire        dev_reset,
	// Register writes.
	input  wire        wr_valid,
	input  wire [3:0]  wr_index,
	// Pointer uses.
	input  wire        ptr_valid,
	input  wire [3:0]  ptr_index,
	// State and fault.
	output reg  [14:0] init_mask_q,
	output wire        ptr_fault
);

	// Register 15 is never cleared, so it always reads initialized.
	wire [15:0] init_all;

	assign init_all  = {1'b1, init_mask_q};
	// A pointer use of a register not yet written is a fault.
	assign ptr_fault = ptr_valid & ~init_all[ptr_index];

	// Any reset clears the marks; a write marks its register initialized.
	always @(posedge aclk) begin
		if (!aresetn || dev_reset) begin
			init_mask_q <= 15'h0000;
		end else if (wr_valid && wr_index != 4'hf) begin
			init_mask_q[wr_index] <= 1'b1;
		end
	end

endmodule // wreg_init_tracker

`default_nettype wire

// >>> hdl/reset_cause_capture.v
// Reset-cause capture block with AXI4-Lite register access.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_regs.vh"

module reset_cause_capture (
	// Clock and reset.
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address.
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	// AXI4-Lite write data.
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response.
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read address.
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	// AXI4-Lite read data.
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Core events, same clock.
	input  wire        fetch_valid,
	input  wire [23:0] fetch_word,
	input  wire        wreg_write_valid,
	input  wire [3:0]  wreg_write_index,
	input  wire        wreg_ptr_valid,
	input  wire [3:0]  wreg_ptr_index,
	input  wire        pc_reload_valid,
	input  wire        pc_reload_vector,
	input  wire [23:0] pc_reload_target,
	input  wire        trap_conflict,
	input  wire        software_reset_instruction,
	input  wire        watchdog_timeout,
	input  wire        watchdog_clear_instruction,
	input  wire        power_save_instruction,
	input  wire        power_save_idle,
	// Cell disturbance of pin-select storage.
	input  wire        pps_upset_valid,
	input  wire [1:0]  pps_upset_index,
	input  wire [15:0] pps_upset_mask,
	// Asynchronous reset sources.
	input  wire        master_clear_pin_n,
	input  wire        por_detect,
	input  wire        bor_detect,
	// Outputs.
	output reg         device_reset_req_q,
	output wire [15:0] reset_cause_status,
	output wire [63:0] pps_select
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions.
	// Maps a byte address to a register select code.
	function [2:0] reg_sel;
		input [7:0] a;
		begin
			if (a == `RC_OFF_STATUS)
				reg_sel = `RC_SEL_STATUS;
			else if (a == `RC_OFF_CTRL)
				reg_sel = `RC_SEL_CTRL;
			else if (a == `RC_OFF_SEG_BASE)
				reg_sel = `RC_SEL_SEG_BASE;
			else if (a == `RC_OFF_SEG_LIMIT)
				reg_sel = `RC_SEL_SEG_LIMIT;
			else if (a >= `RC_OFF_PPS0 && a <= `RC_OFF_PPS3 && a[1:0] == 2'b00)
				reg_sel = `RC_SEL_PPS;
			else if (a == `RC_OFF_WREG_INIT)
				reg_sel = `RC_SEL_WREG_INIT;
			else
				reg_sel = `RC_SEL_NONE;
		end
	endfunction

	// Merges write data into an old value under byte strobes.
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					wmerge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	// Decodes the illegal opcode from the upper byte of a fetched word.
	function is_illegal;
		input [23:0] w;
		begin
			is_illegal = (w[23:16] == `RC_ILLEGAL_OP);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	reg  [15:0] status_q;
	reg  [15:0] status_d;
	reg         sec_en_q;
	reg  [23:0] seg_base_q;
	reg  [23:0] seg_limit_q;
	reg  [15:0] pps_q    [0:3];
	reg  [15:0] shadow_q [0:3];
	reg         aw_held_q;
	reg  [7:0]  aw_addr_q;
	reg         w_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg  [2:0]  master_clear_pin_sync_q;
	reg  [2:0]  por_sync_q;
	reg  [2:0]  bor_sync_q;
	reg  [31:0] rd_word;
	wire        mismatch;
	wire [31:0] status_merged;
	wire [31:0] base_merged;
	wire [31:0] limit_merged;
	wire [31:0] pps_merged;
	wire [14:0] wreg_init;
	wire        wreg_fault;
	wire        wr_fire;
	wire [2:0]  wr_sel;
	wire [2:0]  rd_sel;
	wire [1:0]  wr_pps_idx;
	wire [1:0]  rd_pps_idx;
	wire        ev_master_clear_pin;
	wire        ev_por;
	wire        ev_bor;
	wire        ev_opcode;
	wire        ev_security;
	wire        ev_illegal;
	wire        any_reset;
	integer     k;

	////////////////////////////////////////////////////////////////////////////////
	// Working-register tracker.

	wreg_init_tracker u_wreg (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.dev_reset   (device_reset_req_q),
		.wr_valid    (wreg_write_valid),
		.wr_index    (wreg_write_index),
		.ptr_valid   (wreg_ptr_valid),
		.ptr_index   (wreg_ptr_index),
		.init_mask_q (wreg_init),
		.ptr_fault   (wreg_fault)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 0 feeds only stage 1, stage 2 is the edge history.

	always @(posedge aclk) begin
		if (!aresetn) begin
			master_clear_pin_sync_q <= 3'h7;
			por_sync_q  <= 3'h0;
			bor_sync_q  <= 3'h0;
		end else begin
			master_clear_pin_sync_q <= {master_clear_pin_sync_q[1:0], master_clear_pin_n};
			por_sync_q  <= {por_sync_q[1:0], por_detect};
			bor_sync_q  <= {bor_sync_q[1:0], bor_detect};
		end
	end

	// Assertion edges of the synchronised pins.
	assign ev_master_clear_pin = master_clear_pin_sync_q[2] & ~master_clear_pin_sync_q[1];
	assign ev_por  = por_sync_q[1] & ~por_sync_q[2];
	assign ev_bor  = bor_sync_q[1] & ~bor_sync_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// Fault detection.
	// An illegal word reaching execution resets rather than executes.
	assign ev_opcode = fetch_valid & is_illegal(fetch_word);

	// Both program-flow and vector-flow reloads are checked against the segment.
	assign ev_security = sec_en_q & pc_reload_valid &
		(pc_reload_target >= seg_base_q) & (pc_reload_target <= seg_limit_q);

	assign ev_illegal = ev_opcode | wreg_fault | ev_security;

	// Continuous comparison of every pin-select register with its shadow.
	assign mismatch = (((pps_q[0] ^ shadow_q[0]) | (pps_q[1] ^ shadow_q[1]) |
		(pps_q[2] ^ shadow_q[2]) | (pps_q[3] ^ shadow_q[3])) & `RC_PPS_MASK) != 16'h0000;

	// Every source that resets the device.
	assign any_reset = mismatch | ev_illegal | trap_conflict | ev_master_clear_pin |
		software_reset_instruction | watchdog_timeout | ev_por | ev_bor;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data held independently.
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
	assign wr_fire       = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign wr_sel        = reg_sel(aw_addr_q);
	assign wr_pps_idx    = aw_addr_q[3:2];
	assign status_merged = wmerge({16'h0000, status_q}, w_data_q, w_strb_q);
	assign base_merged   = wmerge({8'h00, seg_base_q}, w_data_q, w_strb_q);
	assign limit_merged  = wmerge({8'h00, seg_limit_q}, w_data_q, w_strb_q);
	assign pps_merged    = wmerge({16'h0000, shadow_q[wr_pps_idx]}, w_data_q, w_strb_q);

	// Capture of each write channel and the response.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q    <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_held_q     <= 1'b0;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_sel == `RC_SEL_NONE || wr_sel == `RC_SEL_WREG_INIT) ?
					`RC_RESP_SLVERR : `RC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control and segment registers.
	always @(posedge aclk) begin
		if (!aresetn) begin
			sec_en_q    <= 1'b0;
			seg_base_q  <= `RC_SEG_RESET;
			seg_limit_q <= `RC_SEG_RESET;
		end else if (wr_fire) begin
			if (wr_sel == `RC_SEL_CTRL)
				sec_en_q <= w_strb_q[0] ? w_data_q[`RC_CTRL_SEC_EN] : sec_en_q;
			if (wr_sel == `RC_SEL_SEG_BASE)
				seg_base_q <= base_merged[23:0];
			if (wr_sel == `RC_SEL_SEG_LIMIT)
				seg_limit_q <= limit_merged[23:0];
		end
	end

	// Pin-select storage: a bus write updates value and shadow together, an upset only
	// the value; a device reset returns both to zero so a mismatch cannot persist.
	always @(posedge aclk) begin
		if (!aresetn || device_reset_req_q) begin
			for (k = 0; k < `RC_PPS_COUNT; k = k + 1) begin
				pps_q[k]    <= 16'h0000;
				shadow_q[k] <= 16'h0000;
			end
		end else begin
			if (pps_upset_valid)
				pps_q[pps_upset_index] <= pps_q[pps_upset_index] ^ pps_upset_mask;
			if (wr_fire && wr_sel == `RC_SEL_PPS) begin
				pps_q[wr_pps_idx]    <= pps_merged[15:0] & `RC_PPS_MASK;
				shadow_q[wr_pps_idx] <= pps_merged[15:0] & `RC_PPS_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset-cause status: writes, then hardware clears, then hardware sets.
	always @* begin
		status_d = status_q;
		if (wr_fire && wr_sel == `RC_SEL_STATUS)
			status_d = status_merged[15:0] & `RC_STATUS_MASK;
		if (ev_por)
			status_d = 16'h0000;
		else if (ev_bor)
			status_d = status_d & `RC_STATUS_KEEP_BOR;
		if (power_save_instruction || watchdog_clear_instruction)
			status_d[`RC_BIT_WDT] = 1'b0;
		if (trap_conflict)
			status_d[`RC_BIT_TRAP] = 1'b1;
		if (ev_illegal)
			status_d[`RC_BIT_ILLEGAL] = 1'b1;
		if (mismatch)
			status_d[`RC_BIT_MISMATCH] = 1'b1;
		if (ev_master_clear_pin)
			status_d[`RC_BIT_EXT] = 1'b1;
		if (software_reset_instruction)
			status_d[`RC_BIT_SOFT] = 1'b1;
		if (watchdog_timeout)
			status_d[`RC_BIT_WDT] = 1'b1;
		if (power_save_instruction && !power_save_idle)
			status_d[`RC_BIT_SLEEP] = 1'b1;
		if (power_save_instruction && power_save_idle)
			status_d[`RC_BIT_IDLE] = 1'b1;
		if (ev_por || ev_bor)
			status_d[`RC_BIT_BOR] = 1'b1;
		if (ev_por)
			status_d[`RC_BIT_POR] = 1'b1;
	end

	// Flags and reset request move on the same edge; the request never clears flags.
	always @(posedge aclk) begin
		if (!aresetn) begin
			status_q           <= `RC_STATUS_RESET;
			device_reset_req_q <= 1'b0;
		end else begin
			status_q           <= status_d;
			device_reset_req_q <= any_reset;
		end
	end

	assign reset_cause_status = status_q;

	// Pin-select values drive the pin mux, register 0 in the low bits.
	assign pps_select = {pps_q[3], pps_q[2], pps_q[1], pps_q[0]};

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path.
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_sel        = reg_sel(s_axi_araddr);
	assign rd_pps_idx    = s_axi_araddr[3:2];

	// Read data selection.
	always @* begin
		case (rd_sel)
			`RC_SEL_STATUS:    rd_word = {16'h0000, status_q};
			`RC_SEL_CTRL:      rd_word = {31'h0000_0000, sec_en_q};
			`RC_SEL_SEG_BASE:  rd_word = {8'h00, seg_base_q};
			`RC_SEL_SEG_LIMIT: rd_word = {8'h00, seg_limit_q};
			`RC_SEL_PPS:       rd_word = {16'h0000, pps_q[rd_pps_idx]};
			`RC_SEL_WREG_INIT: rd_word = {17'h0_0000, wreg_init};
			default:           rd_word = 32'h0000_0000;
		endcase
	end

	// Read response register.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rd_sel == `RC_SEL_NONE) ? `RC_RESP_SLVERR : `RC_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // reset_cause_capture

`default_nettype wire

// >>> verif/reset_cause_capture_assertions.sv
// Concurrent checks on the reset-cause capture block.
`timescale 1ns/1ps
`default_nettype none

module reset_cause_capture_assertions (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Core events.
	input wire logic        fetch_valid,
	input wire logic [23:0] fetch_word,
	input wire logic        trap_conflict,
	input wire logic        software_reset_instruction,
	input wire logic        watchdog_timeout,
	input wire logic        watchdog_clear_instruction,
	input wire logic        power_save_instruction,
	input wire logic        power_save_idle,
	input wire logic        pps_upset_valid,
	input wire logic [15:0] pps_upset_mask,
	input wire logic        master_clear_pin_n,
	// Outputs.
	input wire logic        device_reset_req_q,
	input wire logic [15:0] reset_cause_status
);
	// All checks run on the core clock and pause while reset is low.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////
	// Reset events set their flag and request a reset at the same edge.
	a_trap_flag: assert property (
		trap_conflict |=> device_reset_req_q && reset_cause_status[15])
		else $error("trap conflict not captured");
	a_soft_flag: assert property (
		software_reset_instruction |=> device_reset_req_q && reset_cause_status[6])
		else $error("software reset not captured");
	a_wdt_flag: assert property (
		watchdog_timeout |=> device_reset_req_q && reset_cause_status[4])
		else $error("watchdog time-out not captured");
	a_illegal_op: assert property (
		fetch_valid && fetch_word[23:16] == 8'h3f |=> device_reset_req_q && reset_cause_status[14])
		else $error("illegal opcode not captured");
	// Power-save entry marks sleep without a reset, or idle; a watchdog clear drops bit 4.
	a_sleep_flag: assert property (
		power_save_instruction && !power_save_idle |=> reset_cause_status[3] && !device_reset_req_q)
		else $error("sleep entry not captured");
	a_idle_flag: assert property (
		power_save_instruction && power_save_idle |=> reset_cause_status[2])
		else $error("idle entry not captured");
	a_wdt_clear: assert property (
		watchdog_clear_instruction && !watchdog_timeout |=> !reset_cause_status[4])
		else $error("watchdog flag not cleared");
	// Power-on leaves only the two supply flags set.
	a_por_value: assert property (
		$rose(aresetn) |-> reset_cause_status == 16'h0003)
		else $error("status wrong after power-on");
	// Flags from slower paths are sticky, so a fixed later look suffices.
	a_mismatch_flag: assert property (
		pps_upset_valid && (pps_upset_mask & 16'h1f1f) != 16'h0000 |-> ##2 reset_cause_status[9])
		else $error("pin-select upset not captured");
	a_ext_pin_flag: assert property (
		$fell(master_clear_pin_n) |-> ##3 reset_cause_status[7])
		else $error("master clear not captured");
endmodule // reset_cause_capture_assertions

bind reset_cause_capture reset_cause_capture_assertions chk_u (.*);

`default_nettype wire

// >>> verif/test_reset_cause_capture.sv
// Directed test of the reset-cause capture block through its register bus and events.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_regs.vh"

module test_reset_cause_capture;
	// Bench-driven inputs, all defined at time zero.
	logic        aclk = '0, aresetn = '0;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic        s_axi_arvalid = '0, s_axi_rready = '0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = '0, wreg_write_index = '0, wreg_ptr_index = '0;
	logic [23:0] fetch_word = '0, pc_reload_target = '0;
	logic        pc_reload_vector = '0, power_save_idle = '0;
	logic [1:0]  pps_upset_index = '0;
	logic [15:0] pps_upset_mask = '0;
	logic        master_clear_pin_n = '1, por_detect = '0, bor_detect = '0;
	logic [9:0]  ev = '0;
	// Design outputs and pulse inputs.
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         device_reset_req_q, fetch_valid, wreg_write_valid, wreg_ptr_valid;
	wire         pc_reload_valid, trap_conflict, software_reset_instruction, watchdog_timeout;
	wire         watchdog_clear_instruction, power_save_instruction, pps_upset_valid;
	wire  [15:0] reset_cause_status;
	wire  [63:0] pps_select;
	int          failures = 0, n_compared = 0;
	logic [31:0] rdat;
	logic [1:0]  resp;

	// One-cycle core events share one pulse vector.
	assign {pps_upset_valid, wreg_write_valid, wreg_ptr_valid, pc_reload_valid, fetch_valid,
		power_save_instruction, watchdog_clear_instruction, watchdog_timeout,
		software_reset_instruction, trap_conflict} = ev;

	// Core clock of 4 ns.
	always #2 aclk = ~aclk;

	reset_cause_capture dut_u (.*);

	////////////////////////////////////////////////////////////////
	// Compares two values and counts the outcome.
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// Writes one word; address and data are released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			resp = s_axi_bresp;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// Reads one word into rdat and resp.
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			rdat = s_axi_rdata;
			resp = s_axi_rresp;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	// Reads a register and expects an OKAY answer with the given data.
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, {`RC_RESP_OKAY, e}, {resp, rdat});
	endtask

	// Checks the status and then clears every flag, as software would.
	task automatic sc(input string n, input logic [15:0] e);
		rc(n, 8'h00, {16'h0000, e});
		wr(8'h00, 32'h0, 4'hf);
	endtask

	// Raises the selected events for one cycle, then lets the effects settle.
	task automatic pulse(input logic [9:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= '0;
		repeat (3) @(posedge aclk);
	endtask

	// Holds an asynchronous source for four cycles.
	task automatic pin_pulse(input int k);
		if (k == 0) master_clear_pin_n <= 1'b0; else if (k == 1) bor_detect <= 1'b1; else por_detect <= 1'b1;
		repeat (4) @(posedge aclk);
		master_clear_pin_n <= 1'b1;
		bor_detect <= 1'b0;
		por_detect <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Cuts a hang short.
	initial begin
		#200000;
		failures++;
		final_report;
	end

	// Main sequence.
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		sc("por value", 16'h0003);
		wr(8'h00, 32'hffff_ffff, 4'hf);
		sc("all flags", 16'hc2df);
		wr(8'h00, 32'hffff_ffff, 4'h2);
		sc("upper byte", 16'hc200);
		rd(8'h40);
		chk("unmapped", {`RC_RESP_SLVERR, 32'h0}, {resp, rdat});
		wr(8'h20, 32'h1, 4'hf);
		chk("ro write", `RC_RESP_SLVERR, resp);
		pulse(10'h001);
		sc("trap", 16'h8000);
		pulse(10'h002);
		sc("soft", 16'h0040);
		pulse(10'h004);
		sc("wdt", 16'h0010);
		pulse(10'h010);
		sc("sleep", 16'h0008);
		power_save_idle <= 1'b1;
		pulse(10'h010);
		sc("idle", 16'h0004);
		pulse(10'h004);
		pulse(10'h008);
		sc("wdt clear", 16'h0000);
		pulse(10'h004);
		pulse(10'h010);
		sc("wdt psave", 16'h0004);
		fetch_word <= 24'h3e_ffff;
		pulse(10'h020);
		sc("legal op", 16'h0000);
		fetch_word <= 24'h3f_0000;
		pulse(10'h020);
		sc("illegal op", 16'h4000);
		wreg_write_index <= 4'h5;
		pulse(10'h100);
		rc("init mask", 8'h20, 32'h0000_0020);
		wreg_ptr_index <= 4'h5;
		pulse(10'h080);
		sc("written ptr", 16'h0000);
		wreg_ptr_index <= 4'hf;
		pulse(10'h080);
		sc("reg15 ptr", 16'h0000);
		wreg_ptr_index <= 4'h3;
		pulse(10'h080);
		sc("uninit ptr", 16'h4000);
		wreg_ptr_index <= 4'h5;
		pulse(10'h080);
		sc("marks cleared", 16'h4000);
		wr(8'h04, 32'h1, 4'hf);
		wr(8'h08, 32'h100, 4'hf);
		wr(8'h0c, 32'h1ff, 4'hf);
		pc_reload_target <= 24'h00_0150;
		pulse(10'h040);
		sc("pfc hit", 16'h4000);
		pc_reload_target <= 24'h00_0200;
		pulse(10'h040);
		sc("pfc miss", 16'h0000);
		pc_reload_vector <= 1'b1;
		pc_reload_target <= 24'h00_01ff;
		pulse(10'h040);
		sc("vfc hit", 16'h4000);
		wr(8'h10, 32'h0101, 4'hf);
		rc("pin select", 8'h10, 32'h0101);
		chk("pin select out", 16'h0101, pps_select[15:0]);
		sc("legit write", 16'h0000);
		pps_upset_mask <= 16'h0004;
		pulse(10'h200);
		sc("mismatch", 16'h0200);
		chk("pin select cleared", 16'h0000, pps_select[15:0]);
		pin_pulse(0);
		rc("ext pin", 8'h00, 32'h0080);
		wr(8'h00, 32'hffff_ffff, 4'hf);
		pin_pulse(1);
		rc("brown-out", 8'h00, 32'h0083);
		pin_pulse(2);
		rc("power-on", 8'h00, 32'h0003);
		wr(8'h00, 32'hffff_ffff, 4'hf);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		sc("second reset", 16'h0003);
		final_report;
	end
endmodule // test_reset_cause_capture

`default_nettype wire
